// >>> src/sbt_defs.svh
`ifndef SBT_DEFS_SVH
`define SBT_DEFS_SVH
// IO addresses
`define SBT_ADDR_MODE    8'h06
`define SBT_ADDR_OPTION  8'h3e
`define SBT_ADDR_INTEN   8'h04
`define SBT_ADDR_INTRQ   8'h05
`define SBT_ADDR_EDGE    8'h0c
// Field positions
`define SBT_SRC_HI       7
`define SBT_SRC_LO       5
`define SBT_PRE_HI       4
`define SBT_PRE_LO       3
`define SBT_BSEL_HI      2
`define SBT_BSEL_LO      0
`define SBT_OPT_BIT      2
`define SBT_IRQ_BIT      2
`define SBT_EDGE_BIT     4
// Reset values
`define SBT_MODE_RST     8'h00
`define SBT_BIT_RST      1'b0
`endif

// >>> src/sbt_pkg.sv
package sbt_pkg;
  typedef enum logic [2:0] {
    SBT_SRC_OFF  = 3'b000,
    SBT_SRC_SYS  = 3'b001,
    SBT_SRC_RSV  = 3'b010,
    SBT_SRC_PIN  = 3'b011,
    SBT_SRC_FAST = 3'b100,
    SBT_SRC_XTAL = 3'b101,
    SBT_SRC_SLOW = 3'b110,
    SBT_SRC_R7   = 3'b111
  } sbt_src_e;
endpackage

// >>> src/sbt_tick_if.sv
`timescale 1ns/100ps
`default_nettype none
interface sbt_tick_if;
  logic       tick;
  logic       enable;
  logic       div2_set;
  logic [1:0] ratio;
  modport src (output tick, input enable, input div2_set, input ratio);
  modport snk (input tick, output enable, output div2_set, output ratio);
endinterface
`default_nettype wire

// >>> src/sbt_prescale.sv
`timescale 1ns/100ps
`default_nettype none
module sbt_prescale
(
  // Clock and reset
  input  wire logic  i_core_clk,
  input  wire logic  i_rstn,
  input  wire logic  i_ce,
  // Source clock edge
  input  wire logic  i_src_edge,
  // Tick carrier
  sbt_tick_if.src    tk
);
  logic [6:0] div_cnt;
  logic [6:0] limit;
  logic       wrap;

  // Ratio to terminal count
  function automatic logic [6:0] sbt_limit(input logic set2, input logic [1:0] r);
    logic [7:0] d;
    d = 8'h01 << {r, 1'b0};
    if (set2)
      d = d << 1;
    sbt_limit = 7'(d - 8'h01);
  endfunction

  assign limit = sbt_limit(tk.div2_set, tk.ratio);
  assign wrap  = (div_cnt >= limit);

  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      div_cnt <= 7'h00;
      tk.tick <= 1'b0;
    end
    else if (i_ce)
    begin
      tk.tick <= 1'b0;
      if (!tk.enable)
        div_cnt <= 7'h00;
      else if (i_src_edge)
      begin
        div_cnt <= wrap ? 7'h00 : 7'(div_cnt + 7'h01);
        tk.tick <= wrap;
      end
    end
  end

  a_tick_needs_en : assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    (tk.tick && $past(i_ce)) |-> $past(tk.enable)) else $error("tick while disabled");
endmodule
`default_nettype wire

// >>> src/sbt_timer.sv
`timescale 1ns/100ps
`default_nettype none
`include "sbt_defs.svh"
module sbt_timer
(
  // Clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_rstn,
  input  wire logic        i_ce,
  // IO register port
  input  wire logic [7:0]  i_io_addr,
  input  wire logic        i_io_wr,
  input  wire logic        i_io_rd,
  input  wire logic [7:0]  i_io_wdata,
  output logic      [7:0]  o_io_rdata,
  // Clock sources, asynchronous
  input  wire logic        i_port_a_pin_four,
  input  wire logic        i_internal_fast_rc_osc,
  input  wire logic        i_external_crystal_osc,
  input  wire logic        i_internal_slow_rc_osc,
  // Status
  output logic [15:0]      o_count,
  output logic             o_irq_flag,
  output logic             o_irq
);
  logic [7:0]  timer_mode_control;
  logic        opt_div2;
  logic        irq_en;
  logic        edge_fall;
  logic        irq_flag;
  logic [15:0] count;
  logic [3:0]  s1;
  logic [3:0]  s2;
  logic [3:0]  s3;
  logic        sel_bit_q;
  logic        sel_bit_vld;
  logic [7:0]  rdata;
  logic        irq_q;

  sbt_tick_if tk ();

  // ---------------------------------------------
  // Register decode
  // ---------------------------------------------
  wire logic wr_mode  = i_io_wr && (i_io_addr == `SBT_ADDR_MODE);
  wire logic wr_opt   = i_io_wr && (i_io_addr == `SBT_ADDR_OPTION);
  wire logic wr_en    = i_io_wr && (i_io_addr == `SBT_ADDR_INTEN);
  wire logic wr_rq    = i_io_wr && (i_io_addr == `SBT_ADDR_INTRQ);
  wire logic wr_edge  = i_io_wr && (i_io_addr == `SBT_ADDR_EDGE);
  wire logic [2:0] src  = timer_mode_control[`SBT_SRC_HI:`SBT_SRC_LO];
  wire logic [1:0] pre  = timer_mode_control[`SBT_PRE_HI:`SBT_PRE_LO];
  wire logic [2:0] bsel = timer_mode_control[`SBT_BSEL_HI:`SBT_BSEL_LO];

  // ---------------------------------------------
  // Source selection
  // ---------------------------------------------
  // Synchronised rising edges of asynchronous sources (s2 high while s3 still low)
  wire logic [3:0] rise = s2 & ~s3;
  wire logic sys_src  = (src == sbt_pkg::SBT_SRC_SYS);
  wire logic src_edge =
    sys_src ? 1'b1 :
    (src == sbt_pkg::SBT_SRC_PIN)  ? rise[0] :
    (src == sbt_pkg::SBT_SRC_FAST) ? rise[1] :
    (src == sbt_pkg::SBT_SRC_XTAL) ? rise[2] :
    (src == sbt_pkg::SBT_SRC_SLOW) ? rise[3] : 1'b0;
  wire logic src_on = sys_src || (src == sbt_pkg::SBT_SRC_PIN) ||
    (src == sbt_pkg::SBT_SRC_FAST) || (src == sbt_pkg::SBT_SRC_XTAL) ||
    (src == sbt_pkg::SBT_SRC_SLOW);

  assign tk.enable   = src_on;
  assign tk.div2_set = opt_div2;
  assign tk.ratio    = pre;

  sbt_prescale u_pre
  (
    .i_core_clk (i_core_clk),
    .i_rstn     (i_rstn),
    .i_ce       (i_ce),
    .i_src_edge (src_edge),
    .tk         (tk)
  );

  // ---------------------------------------------
  // Interrupt bit selection
  // ---------------------------------------------
  function automatic logic sbt_pick(input logic [15:0] c, input logic [2:0] s);
    sbt_pick = c[{1'b1, s}];
  endfunction

  wire logic sel_bit  = sbt_pick(count, bsel);
  wire logic sel_valid = (bsel != 3'h3);
  wire logic hit = sel_valid && sel_bit_vld &&
    (edge_fall ? (sel_bit_q && !sel_bit) : (!sel_bit_q && sel_bit));

  // ---------------------------------------------
  // Read mux
  // ---------------------------------------------
  always_comb
  begin
    rdata = 8'h00;
    if (i_io_addr == `SBT_ADDR_MODE)
      rdata = timer_mode_control;
    else if (i_io_addr == `SBT_ADDR_INTEN)
      rdata = {5'h00, irq_en, 2'h0};
    else if (i_io_addr == `SBT_ADDR_INTRQ)
      rdata = {5'h00, irq_flag, 2'h0};
  end

  // ---------------------------------------------
  // Registers
  // ---------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      timer_mode_control <= `SBT_MODE_RST;
      opt_div2           <= `SBT_BIT_RST;
      irq_en             <= `SBT_BIT_RST;
      edge_fall          <= `SBT_BIT_RST;
      s1                 <= 4'h0;
      s2                 <= 4'h0;
      s3                 <= 4'h0;
    end
    else if (i_ce)
    begin
      s1 <= {i_internal_slow_rc_osc, i_external_crystal_osc,
             i_internal_fast_rc_osc, i_port_a_pin_four};
      s2 <= s1;
      s3 <= s2;
      if (wr_mode)
        timer_mode_control <= i_io_wdata;
      if (wr_opt)
        opt_div2 <= i_io_wdata[`SBT_OPT_BIT];
      if (wr_en)
        irq_en <= i_io_wdata[`SBT_IRQ_BIT];
      if (wr_edge)
        edge_fall <= i_io_wdata[`SBT_EDGE_BIT];
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      count       <= 16'h0000;
      sel_bit_q   <= 1'b0;
      sel_bit_vld <= 1'b0;
      irq_flag    <= 1'b0;
      irq_q       <= 1'b0;
      o_io_rdata  <= 8'h00;
    end
    else if (i_ce)
    begin
      if (tk.tick)
        count <= 16'(count + 16'h0001);
      sel_bit_q   <= sel_bit;
      sel_bit_vld <= !wr_mode;
      if (hit)
        irq_flag <= 1'b1;
      else if (wr_rq && !i_io_wdata[`SBT_IRQ_BIT])
        irq_flag <= 1'b0;
      irq_q <= (hit || irq_flag) && irq_en;
      if (i_io_rd)
        o_io_rdata <= rdata;
    end
  end

  assign o_count    = count;
  assign o_irq_flag = irq_flag;
  assign o_irq      = irq_q;

  // ---------------------------------------------
  // Checks
  // ---------------------------------------------
  a_off_no_count : assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    (i_ce && $past(i_ce) && !src_on && !$past(src_on)) |=> $stable(count))
    else $error("counts while off");
  a_count_step : assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    (i_ce && tk.tick) |=> (count == 16'($past(count) + 16'h0001))) else $error("bad step");
  a_sys_tick : assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    (i_ce && sys_src && !opt_div2 && pre == 2'b00 && $past(sys_src) && $past(i_ce) &&
     !$past(opt_div2) && $past(pre) == 2'b00)
    |-> tk.tick) else $error("sysclk /1 missing tick");
  a_flag_set : assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    (i_ce && hit) |=> irq_flag) else $error("event lost");
  a_irq_gate : assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    (i_ce && !irq_en) |=> !o_irq) else $error("irq while masked");
  a_irq_on : assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    (i_ce && irq_en && irq_flag) |=> o_irq) else $error("irq missing");
  a_edge_dir : assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    hit |-> (sel_bit == !edge_fall)) else $error("wrong edge");
  a_code3_none : assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    (bsel == 3'h3) |-> !hit) else $error("code 3 raised event");
  a_ce_freeze : assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    !i_ce |=> $stable(count)) else $error("counts while frozen");
  a_flag_clear : assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    (i_ce && wr_rq && !i_io_wdata[`SBT_IRQ_BIT] && !hit) |=> !irq_flag)
    else $error("flag not cleared");
  a_flag_hold : assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    (irq_flag && !(i_ce && wr_rq && !i_io_wdata[`SBT_IRQ_BIT])) |=> irq_flag)
    else $error("flag dropped");
  a_mode_write : assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    (i_ce && wr_mode) |=> (timer_mode_control == $past(i_io_wdata)))
    else $error("mode write lost");
  a_opt_write : assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    (i_ce && wr_opt) |=> (opt_div2 == $past(i_io_wdata[`SBT_OPT_BIT])))
    else $error("option write lost");
  a_en_write : assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    (i_ce && wr_en) |=> (irq_en == $past(i_io_wdata[`SBT_IRQ_BIT])))
    else $error("enable write lost");
  a_edge_write : assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    (i_ce && wr_edge) |=> (edge_fall == $past(i_io_wdata[`SBT_EDGE_BIT])))
    else $error("edge write lost");
endmodule
`default_nettype wire

// >>> test/sbt_timer_tb.sv
`timescale 1ns/100ps
`default_nettype none
module sbt_timer_tb;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [7:0]  wdata = 8'h00;
  logic [7:0]  rdata;
  logic [5:0]  ph = 6'h00;
  logic        ce = 1'b1;
  logic [15:0] cnt;
  logic        flag;
  logic        irq;
  logic [15:0] c0;
  int          err_total = 0;
  int          n_checks = 0;
  int          div;
  int          e;

  always #5 clk = ~clk;

  // Source phases, rising edges every 8, 16, 32 and 64 cycles
  always
  begin
    @(posedge clk);
    #1 ph = ph + 6'h01;
  end

  sbt_timer u_sbt_timer
  (
    .i_core_clk             (clk),
    .i_rstn                 (rstn),
    .i_ce                   (ce),
    .i_io_addr              (addr),
    .i_io_wr                (wr),
    .i_io_rd                (rd),
    .i_io_wdata             (wdata),
    .o_io_rdata             (rdata),
    .i_port_a_pin_four      (ph[2]),
    .i_internal_fast_rc_osc (ph[3]),
    .i_external_crystal_osc (ph[4]),
    .i_internal_slow_rc_osc (ph[5]),
    .o_count                (cnt),
    .o_irq_flag             (flag),
    .o_irq                  (irq)
  );

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic io_wr(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    tick(1);
    wr = 1'b0;
    tick(1);
  endtask

  task automatic chk(input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    addr = a;
    rd = 1'b1;
    tick(1);
    rd = 1'b0;
    chk({8'h00, exp}, {8'h00, rdata});
    tick(1);
  endtask

  task automatic rate(input logic [7:0] opt, input logic [7:0] mode, input int span,
                      input int exp);
    io_wr(8'h3e, opt);
    io_wr(8'h06, mode);
    tick(8);
    c0 = cnt;
    tick(span);
    chk(c0 + 16'(exp), cnt);
  endtask

  task automatic wait_flag;
    e = 0;
    while (flag !== 1'b1 && e < 1200)
    begin
      tick(1);
      e++;
    end
    chk(16'h0001, {15'h0000, flag});
  endtask

  task automatic report_and_stop;
    $display("checks=%0d mismatches=%0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    #300000;
    err_total++;
    report_and_stop();
  end

  initial
  begin
    tick(16);
    rstn = 1'b1;
    tick(20);
    chk(16'h0000, cnt);
    rd_chk(8'h06, 8'h00);
    rd_chk(8'h04, 8'h00);
    rd_chk(8'h05, 8'h00);
    rd_chk(8'h3e, 8'h00);
    io_wr(8'h06, 8'hab);
    rd_chk(8'h06, 8'hab);
    rd_chk(8'h07, 8'h00);
    $display("test registers done");
    for (int k = 0; k < 8; k++)
    begin
      div = (k >= 4 ? 2 : 1) << (2 * (k % 4));
      rate({5'h00, k[2], 2'b00}, {3'b001, k[1:0], 3'b000}, 4 * div, 4);
    end
    $display("test prescaler done");
    for (int k = 0; k < 8; k++)
    begin
      e = (k == 1) ? 320 : ((k >= 3 && k <= 6) ? (320 >> k) : 0);
      rate(8'h00, {k[2:0], 5'h00}, 320, e);
    end
    $display("test sources done");
    io_wr(8'h0c, 8'h00);
    io_wr(8'h04, 8'h04);
    io_wr(8'h06, 8'h20);
    io_wr(8'h05, 8'h00);
    wait_flag();
    chk(16'h0001, {15'h0000, cnt[8]});
    tick(2);
    chk(16'h0001, {15'h0000, irq});
    rd_chk(8'h05, 8'h04);
    io_wr(8'h05, 8'h00);
    chk(16'h0000, {15'h0000, flag});
    io_wr(8'h04, 8'h00);
    tick(2);
    chk(16'h0000, {15'h0000, irq});
    io_wr(8'h0c, 8'h10);
    io_wr(8'h06, 8'h21);
    wait_flag();
    chk(16'h0000, {15'h0000, cnt[9]});
    chk(16'h0000, {15'h0000, irq});
    ce = 1'b0;
    tick(1);
    c0 = cnt;
    tick(20);
    chk(c0, cnt);
    ce = 1'b1;
    $display("test interrupt done");
    report_and_stop();
  end
endmodule
`default_nettype wire
